// file: inc/rx_irq_pkg.sv
// constants shared by the receive interrupt moderation block
package rx_irq_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] PKT_DELAY_OFF   = 8'h00;
  localparam logic [7:0] ABS_DELAY_OFF   = 8'h04;
  localparam logic [7:0] SMALL_THR_OFF   = 8'h08;
  localparam logic [7:0] RX_CTRL_OFF     = 8'h0C;
  localparam logic [7:0] CAUSE_OFF       = 8'h10;
  localparam logic [7:0] MASK_OFF        = 8'h14;
  localparam logic [7:0] RING_SIZE_OFF   = 8'h18;
  localparam logic [7:0] STATUS_OFF      = 8'h1C;

  // field positions
  localparam int FLUSH_BIT        = 31;
  localparam int DELAY_W          = 16;
  localparam int SIZE_W           = 12;
  localparam int CTRL_SEL_LSB     = 0;
  localparam int CTRL_STRIP_CRC   = 2;
  localparam int CTRL_KEEP_TIMERS = 3;
  localparam int CTRL_LEGACY      = 4;
  localparam int CTRL_W           = 5;
  localparam int CAUSE_TIMER      = 0;
  localparam int CAUSE_SMALL      = 1;
  localparam int CAUSE_DESC_LOW   = 2;
  localparam int CAUSE_OVERRUN    = 3;
  localparam int CAUSE_W          = 4;

  // values after reset
  localparam logic [DELAY_W-1:0] PKT_DELAY_RST = 16'h0000;
  localparam logic [DELAY_W-1:0] ABS_DELAY_RST = 16'h0000;
  localparam logic [SIZE_W-1:0]  SMALL_THR_RST = 12'h000;
  localparam logic [CTRL_W-1:0]  RX_CTRL_RST   = 5'h00;
  localparam logic [CAUSE_W-1:0] MASK_RST      = 4'h0;
  localparam logic [15:0]        RING_SIZE_RST = 16'h0008;

  // bytes removed by stripping
  localparam logic [15:0] FCS_BYTES  = 16'h0004;
  localparam logic [15:0] VLAN_BYTES = 16'h0004;

  // delay timer time base
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS       = 1024;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 5;

  typedef enum logic [1:0] {
    FL_IDLE = 2'b00,
    FL_WAIT = 2'b01
  } flush_state_t;

endpackage

// file: rtl/rx_interrupt_moderation.sv
// receive interrupt moderation: delay timers, cause register and apb slave
//
// Notes on behaviour
// RULE_01 - each completed packet reloads and starts the packet delay timer.
// RULE_02 - packet delay timer running out raises the receive timer cause.
// RULE_03 - packet delay zero disables both timers; every packet raises receive timer.
// RULE_04 - flush bit write flushes descriptors, expires packet timer, raises receive timer.
// RULE_05 - absolute expiry or small packet reloads packet timer, left stopped.
// RULE_06 - first completed packet starts absolute timer; later packets do not restart it.
// RULE_07 - absolute delay timer running out raises the receive timer cause.
// RULE_08 - absolute timer disabled when either delay value is zero.
// RULE_09 - software disables only packet timer by setting it to absolute plus one.
// RULE_10 - packet expiry or small packet reloads absolute timer, left stopped.
// RULE_11 - packet timer expired mid transfer restarts only after that transfer completes.
// RULE_12 - non-zero size limit: packets at or below it raise small packet cause.
// RULE_13 - size counts headers and fcs unless stripped; stripped fcs and vlan excluded.
// RULE_14 - small packet cause also sets the receive timer cause.
// RULE_15 - selectable variant keeps both timers running on a small packet.
// RULE_16 - free descriptors equal to ring fraction raises descriptor low cause.
// RULE_17 - byte write into a full receive fifo raises overrun cause.
// RULE_18 - overrunning packet is dropped whole; following packets unaffected.
// RULE_19 - legacy variant: one timer from first packet after write; expiry flushes, signals.
// RULE_20 - legacy flush bit write flushes used descriptors and updates head pointer.
// RULE_21 - four separate receive causes recorded in the interrupt cause register.
// RULE_22 - timer expiry flushes used descriptors before receive timer is signalled.
// RULE_23 - timers count down per time base tick; expire on reaching zero while running.
// RULE_24 - causes stay set until software clears; interrupt when set and enabled.
`timescale 1ns/10ps
`default_nettype none

module rx_interrupt_moderation
  import rx_irq_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // receive datapath events
  input  wire logic        i_pkt_done,
  input  wire logic [15:0] i_pkt_len,
  input  wire logic        i_pkt_vlan_stripped,
  input  wire logic        i_xfer_busy,
  input  wire logic [15:0] i_free_desc,
  input  wire logic        i_fifo_wr,
  input  wire logic        i_fifo_full,
  input  wire logic        i_rx_eop,
  input  wire logic        i_wb_done,
  // outputs
  output logic             o_flush_req,
  output logic             o_head_update,
  output logic             o_drop_pkt,
  output logic             o_irq
);

  logic                rst_meta_q;
  logic                rst_n_q;
  logic [DELAY_W-1:0]  pkt_delay_q;
  logic [DELAY_W-1:0]  abs_delay_q;
  logic [SIZE_W-1:0]   small_thr_q;
  logic [CTRL_W-1:0]   ctrl_q;
  logic [CAUSE_W-1:0]  cause_q;
  logic [CAUSE_W-1:0]  mask_q;
  logic [15:0]         ring_size_q;
  logic [TICK_W-1:0]   tick_cnt_q;
  logic                tick;
  logic [DELAY_W-1:0]  pkt_cnt_q;
  logic                pkt_run_q;
  logic [DELAY_W-1:0]  abs_cnt_q;
  logic                abs_run_q;
  logic                legacy_armed_q;
  flush_state_t        fl_state_q;
  logic                desc_eq_q;
  logic                drop_q;
  logic                flush_req_q;
  logic                head_upd_q;
  logic [31:0]         rdata_q;

  logic                wr_en;
  logic                setup;
  logic                mapped;
  logic                wr_pkt_delay;
  logic                flush_wr;
  logic                legacy;
  logic                abs_enable;
  logic                pkt_expire;
  logic                abs_expire;
  logic                small_hit;
  logic                zero_delay_hit;
  logic                timer_event;
  logic                small_stops;
  logic [15:0]         eff_len;
  logic [15:0]         desc_thr;
  logic                desc_eq;
  logic                overrun;
  logic                timer_cause_set;
  logic [CAUSE_W-1:0]  cause_set;
  logic [CAUSE_W-1:0]  cause_clr;

  // reset release through two flip-flops
  // the assert is immediate; only the release is synchronised to the clock
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // apb decode: zero wait states, read data captured in the setup cycle
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite;
  // no wait states: every read comes from a flop captured in the setup cycle
  assign pready  = 1'b1;
  // unmapped offsets answer with an error rather than a silent zero
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = rdata_q;

  always_comb begin
    case (paddr)
      PKT_DELAY_OFF, ABS_DELAY_OFF, SMALL_THR_OFF, RX_CTRL_OFF,
      CAUSE_OFF, MASK_OFF, RING_SIZE_OFF, STATUS_OFF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        PKT_DELAY_OFF: rdata_q <= {16'h0000, pkt_delay_q};
        ABS_DELAY_OFF: rdata_q <= {16'h0000, abs_delay_q};
        SMALL_THR_OFF: rdata_q <= {20'h00000, small_thr_q};
        RX_CTRL_OFF:   rdata_q <= {27'h0000000, ctrl_q};
        CAUSE_OFF:     rdata_q <= {28'h0000000, cause_q};
        MASK_OFF:      rdata_q <= {28'h0000000, mask_q};
        RING_SIZE_OFF: rdata_q <= {16'h0000, ring_size_q};
        STATUS_OFF:    rdata_q <= {27'h0000000, drop_q, fl_state_q == FL_WAIT,
                                   legacy_armed_q, abs_run_q, pkt_run_q};
        default:       rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // software registers
  assign wr_pkt_delay = wr_en && (paddr == PKT_DELAY_OFF);
  assign flush_wr     = wr_pkt_delay & pwdata[FLUSH_BIT];

  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pkt_delay_q <= PKT_DELAY_RST;
      abs_delay_q <= ABS_DELAY_RST;
      small_thr_q <= SMALL_THR_RST;
      ctrl_q      <= RX_CTRL_RST;
      mask_q      <= MASK_RST;
      ring_size_q <= RING_SIZE_RST;
    end else if (wr_en) begin
      case (paddr)
        PKT_DELAY_OFF: pkt_delay_q <= pwdata[DELAY_W-1:0];
        ABS_DELAY_OFF: abs_delay_q <= pwdata[DELAY_W-1:0];
        SMALL_THR_OFF: small_thr_q <= pwdata[SIZE_W-1:0];
        RX_CTRL_OFF:   ctrl_q      <= pwdata[CTRL_W-1:0];
        MASK_OFF:      mask_q      <= pwdata[CAUSE_W-1:0];
        RING_SIZE_OFF: ring_size_q <= pwdata[15:0];
        default:       ;
      endcase
    end
  end

  assign legacy      = ctrl_q[CTRL_LEGACY];
  assign small_stops = ~ctrl_q[CTRL_KEEP_TIMERS];                              // [RULE_15]
  assign abs_enable  = (abs_delay_q != '0) && (pkt_delay_q != '0) && !legacy; // [RULE_08]

  // time base shared by both timers
  // 1024 ns is not a whole number of clocks, so each tick runs slightly fast
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end
  assign tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));

  // small packet test on the length as stored in host memory
  always_comb begin
    eff_len = i_pkt_len;
    if (ctrl_q[CTRL_STRIP_CRC]) begin
      eff_len = eff_len - FCS_BYTES;                                            // [RULE_13]
    end
    if (i_pkt_vlan_stripped) begin
      eff_len = eff_len - VLAN_BYTES;                                           // [RULE_13]
    end
  end
  assign small_hit = i_pkt_done && !legacy && (small_thr_q != '0) &&
                     (eff_len <= {4'h0, small_thr_q});                         // [RULE_12]

  // expiry: count reaches zero on a tick while running
  // a count of one expires at the next tick, so a delay of n lasts at most n ticks
  assign pkt_expire = pkt_run_q && tick && (pkt_cnt_q <= 16'h0001);            // [RULE_23]
  assign abs_expire = abs_run_q && tick && (abs_cnt_q <= 16'h0001);            // [RULE_23]
  assign zero_delay_hit = i_pkt_done && (pkt_delay_q == '0);                   // [RULE_03]

  // packet delay timer; in legacy mode it is the single absolute timer
  // i_xfer_busy is not needed: the restart waits for i_pkt_done,
  // which itself marks the end of the transfer in flight
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pkt_cnt_q      <= PKT_DELAY_RST;
      pkt_run_q      <= 1'b0;
      legacy_armed_q <= 1'b0;
    end else begin
      if (wr_pkt_delay) begin
        legacy_armed_q <= 1'b1;                                                 // [RULE_19]
      end
      if (flush_wr) begin
        pkt_run_q <= 1'b0;                                                      // [RULE_04]
        pkt_cnt_q <= pwdata[DELAY_W-1:0];
      end else if (pkt_expire) begin
        // a transfer still in flight restarts it only at its completion
        pkt_run_q <= 1'b0;                                                      // [RULE_11]
        pkt_cnt_q <= pkt_delay_q;
      end else if (legacy) begin
        if (i_pkt_done && legacy_armed_q && pkt_delay_q != '0) begin
          pkt_cnt_q      <= pkt_delay_q;                                        // [RULE_19]
          pkt_run_q      <= 1'b1;
          legacy_armed_q <= 1'b0;
        end else if (pkt_run_q && tick) begin
          pkt_cnt_q <= pkt_cnt_q - 1'b1;
        end
      end else if (zero_delay_hit) begin
        pkt_run_q <= 1'b0;                                                      // [RULE_03]
      end else if ((small_hit && small_stops) || abs_expire) begin
        pkt_run_q <= 1'b0;                                                      // [RULE_05]
        pkt_cnt_q <= pkt_delay_q;
      end else if (i_pkt_done) begin
        pkt_run_q <= 1'b1;                                                      // [RULE_01]
        pkt_cnt_q <= pkt_delay_q;
      end else if (pkt_run_q && tick) begin
        pkt_cnt_q <= pkt_cnt_q - 1'b1;                                          // [RULE_23]
      end
    end
  end

  // absolute delay timer
  // later packets never restart it; only expiry of either timer, flush, a small packet that stops timers or abs_enable low reload it
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      abs_cnt_q <= ABS_DELAY_RST;
      abs_run_q <= 1'b0;
    end else if (!abs_enable) begin
      abs_run_q <= 1'b0;                                                        // [RULE_08]
      abs_cnt_q <= abs_delay_q;
    end else if (abs_expire || pkt_expire || flush_wr ||
                 (small_hit && small_stops)) begin
      abs_run_q <= 1'b0;                                                        // [RULE_10]
      abs_cnt_q <= abs_delay_q;
    end else if (i_pkt_done && !abs_run_q) begin
      abs_run_q <= 1'b1;                                                        // [RULE_06]
      abs_cnt_q <= abs_delay_q;
    end else if (abs_run_q && tick) begin
      abs_cnt_q <= abs_cnt_q - 1'b1;                                            // [RULE_23]
    end
  end

  // descriptor flush ahead of the receive timer cause
  // one flush at a time: events that arrive meanwhile are folded into it
  assign timer_event = pkt_expire ||
                       abs_expire ||
                       flush_wr ||
                       (zero_delay_hit && !legacy) ||
                       (legacy && i_pkt_done && pkt_delay_q == '0);

  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fl_state_q  <= FL_IDLE;
      flush_req_q <= 1'b0;
      head_upd_q  <= 1'b0;
    end else begin
      flush_req_q <= 1'b0;
      head_upd_q  <= 1'b0;
      case (fl_state_q)
        FL_IDLE: begin
          if (timer_event) begin
            flush_req_q <= 1'b1;                                                // [RULE_22]
            fl_state_q  <= FL_WAIT;
          end
        end
        FL_WAIT: begin
          if (i_wb_done) begin
            head_upd_q <= legacy;                                               // [RULE_20]
            fl_state_q <= FL_IDLE;
          end
        end
        default: fl_state_q <= FL_IDLE;
      endcase
    end
  end
  assign o_flush_req   = flush_req_q;
  assign o_head_update = head_upd_q;

  // the timer cause waits for the write-back, except on a small packet; events during the wait share it
  assign timer_cause_set = ((fl_state_q == FL_WAIT) && i_wb_done) || small_hit; // [RULE_14]

  // descriptor low: raised on the cycle the free count becomes equal
  // only the transition counts, so a ring parked at the threshold
  // raises one cause rather than one per cycle
  always_comb begin
    case (ctrl_q[CTRL_SEL_LSB +: 2])
      2'b00:   desc_thr = ring_size_q >> 1;
      2'b01:   desc_thr = ring_size_q >> 2;
      default: desc_thr = ring_size_q >> 3;
    endcase
  end
  assign desc_eq = (i_free_desc == desc_thr);

  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      desc_eq_q <= 1'b0;
    end else begin
      desc_eq_q <= desc_eq;
    end
  end

  // overrun drops the rest of the packet up to its end marker
  assign overrun = i_fifo_wr && i_fifo_full;                                   // [RULE_17]

  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      drop_q <= 1'b0;
    end else if (i_rx_eop) begin
      drop_q <= 1'b0;                                                           // [RULE_18]
    end else if (overrun) begin
      drop_q <= 1'b1;                                                           // [RULE_18]
    end
  end
  assign o_drop_pkt = drop_q;

  // cause register, write one to clear; a new event wins over the clear
  always_comb begin
    cause_set                 = '0;
    cause_set[CAUSE_TIMER]    = timer_cause_set;                                // [RULE_02] [RULE_07]
    cause_set[CAUSE_SMALL]    = small_hit;                                      // [RULE_12]
    cause_set[CAUSE_DESC_LOW] = desc_eq && !desc_eq_q;                          // [RULE_16]
    cause_set[CAUSE_OVERRUN]  = overrun;                                        // [RULE_17]
  end
  assign cause_clr = (wr_en && paddr == CAUSE_OFF) ? pwdata[CAUSE_W-1:0] : '0;

  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cause_q <= '0;
    end else begin
      cause_q <= (cause_q & ~cause_clr) | cause_set;                            // [RULE_21] [RULE_24]
    end
  end

  assign o_irq = |(cause_q & mask_q);                                           // [RULE_24]

endmodule

`default_nettype wire

// file: testbench/rx_irq_chk.sv
// assertion checker for the receive interrupt moderation block
`timescale 1ns/10ps
`default_nettype none
module rx_irq_chk
  import rx_irq_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        i_pkt_done,
  input wire logic        i_fifo_wr,
  input wire logic        i_fifo_full,
  input wire logic        i_rx_eop,
  input wire logic        i_wb_done,
  input wire logic        o_flush_req,
  input wire logic        o_head_update,
  input wire logic        o_drop_pkt,
  input wire logic        o_irq
);
  logic               wr;
  logic [DELAY_W-1:0] dly_q;
  logic [CAUSE_W-1:0] msk_q;
  logic               wait_q;
  assign wr = psel && penable && pwrite && pready;
  // shadows of the registers that gate the properties
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dly_q <= PKT_DELAY_RST;
      msk_q <= MASK_RST;
    end else if (wr) begin
      if (paddr == PKT_DELAY_OFF) dly_q <= pwdata[DELAY_W-1:0];
      if (paddr == MASK_OFF) msk_q <= pwdata[CAUSE_W-1:0];
    end
  end
  // a flush is outstanding until the write-back ends
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) wait_q <= 1'h0;
    else if (o_flush_req) wait_q <= 1'h1;
    else if (i_wb_done) wait_q <= 1'h0;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  property p_pulse; o_flush_req |=> !o_flush_req; endproperty
  a_pulse: assert property (p_pulse) else $error("flush longer than a cycle");
  property p_one; wait_q |-> !o_flush_req; endproperty
  a_one: assert property (p_one) else $error("second flush while waiting");
  property p_zero; dly_q == 0 && i_pkt_done && !wait_q && !o_flush_req |=> o_flush_req; endproperty
  a_zero: assert property (p_zero) else $error("zero delay packet not flushed");
  property p_fpd;
    wr && paddr == PKT_DELAY_OFF && pwdata[FLUSH_BIT] && !wait_q && !o_flush_req
      |-> ##[1:2] o_flush_req;
  endproperty
  a_fpd: assert property (p_fpd) else $error("flush bit write ignored");
  property p_irq; i_wb_done && wait_q && msk_q[CAUSE_TIMER] |-> ##[1:2] o_irq; endproperty
  a_irq: assert property (p_irq) else $error("no interrupt after write-back");
  property p_mask; msk_q == 0 |-> !o_irq; endproperty
  a_mask: assert property (p_mask) else $error("interrupt with all causes masked");
  property p_ovr; i_fifo_wr && i_fifo_full |=> o_drop_pkt; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun packet not dropped");
  property p_drop; o_drop_pkt && !i_rx_eop |=> o_drop_pkt; endproperty
  a_drop: assert property (p_drop) else $error("drop ended inside packet");
  property p_head; o_head_update |-> $past(i_wb_done); endproperty
  a_head: assert property (p_head) else $error("head update without write-back");
  c_flush: cover property (o_flush_req ##[1:20] i_wb_done);
  c_drop: cover property (o_drop_pkt ##1 !o_drop_pkt);
  c_head: cover property (o_head_update);
endmodule
bind rx_interrupt_moderation rx_irq_chk i_chk (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr),
  .pwdata(pwdata), .i_pkt_done(i_pkt_done), .i_fifo_wr(i_fifo_wr), .i_fifo_full(i_fifo_full),
  .i_rx_eop(i_rx_eop), .i_wb_done(i_wb_done), .o_flush_req(o_flush_req),
  .o_head_update(o_head_update), .o_drop_pkt(o_drop_pkt), .o_irq(o_irq));
`default_nettype wire

// file: testbench/rx_host_model.sv
// host side model that answers descriptor flush requests
`timescale 1ns/10ps
`default_nettype none
module rx_host_model (
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  input  wire logic i_flush_req,
  input  wire logic i_slow,
  output logic      o_wb_done
);
  logic [3:0] cnt_q;
  logic       busy_q;
  // slow answers mimic a congested host bus
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_q <= 1'h0;
      cnt_q <= 4'h0;
      o_wb_done <= 1'h0;
    end else begin
      o_wb_done <= 1'h0;
      if (i_flush_req) begin
        busy_q <= 1'h1;
        cnt_q <= i_slow ? 4'hC : 4'h1;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'h0;
        o_wb_done <= 1'h1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the receive interrupt moderation block
`timescale 1ns/10ps
`default_nettype none
module testbench
  import rx_irq_pkg::*;
;
  typedef struct packed {
    logic [11:0] thr;
    logic [15:0] len;
    logic        crc;
    logic        vlan;
    logic        exp;
  } row_t;
  logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        done = 1'h0, vlan = 1'h0, fwr = 1'h0, full = 1'h0, eop = 1'h0, slow = 1'h0;
  logic        pready, perr, wb, flush, head, drop, irq;
  logic [7:0]  paddr = 8'h00;
  logic [15:0] len = 16'h0000, free = 16'h0008;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int          mismatches, samples_checked, n, k, t;
  row_t rows [7] = '{'{12'h040, 16'h0040, 1'h0, 1'h0, 1'h1}, '{12'h040, 16'h0041, 1'h0, 1'h0, 1'h0},
    '{12'h040, 16'h0044, 1'h1, 1'h0, 1'h1}, '{12'h040, 16'h0045, 1'h1, 1'h0, 1'h0},
    '{12'h040, 16'h0048, 1'h1, 1'h1, 1'h1}, '{12'h040, 16'h0044, 1'h0, 1'h1, 1'h1},
    '{12'h000, 16'h000A, 1'h0, 1'h0, 1'h0}};
  logic [31:0] rst_v [8] = '{32'(PKT_DELAY_RST), 32'(ABS_DELAY_RST), 32'(SMALL_THR_RST),
    32'(RX_CTRL_RST), 32'h0, 32'(MASK_RST), 32'(RING_SIZE_RST), 32'h0};
  rx_interrupt_moderation i_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(perr), .prdata(prdata), .i_pkt_done(done), .i_pkt_len(len),
    .i_pkt_vlan_stripped(vlan), .i_xfer_busy(1'h0), .i_free_desc(free), .i_fifo_wr(fwr),
    .i_fifo_full(full), .i_rx_eop(eop), .i_wb_done(wb), .o_flush_req(flush),
    .o_head_update(head), .o_drop_pkt(drop), .o_irq(irq));
  rx_host_model i_host (.i_clk_sys(clk), .i_reset_n(rst_n), .i_flush_req(flush),
    .i_slow(slow), .o_wb_done(wb));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic final_report;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'h1 && i < 20);
    chk(i < 20, 1'h1);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic cause(input logic [31:0] e);
    apb(1'h0, CAUSE_OFF, 32'h0);
    chk(rd, e);
    apb(1'h1, CAUSE_OFF, 32'hF);
  endtask
  task automatic pkt(input logic [15:0] l, input logic v);
    @(posedge clk);
    done <= 1'h1;
    len <= l;
    vlan <= v;
    @(posedge clk);
    done <= 1'h0;
  endtask
  task automatic wfl(input int lim);
    n = 0;
    while (flush !== 1'h1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    $display("Error %0t: run timed out", $time);
    final_report();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    apb(1'h1, PKT_DELAY_OFF, 32'h100);
    foreach (rows[i]) begin
      apb(1'h1, SMALL_THR_OFF, 32'(rows[i].thr));
      apb(1'h1, RX_CTRL_OFF, 32'(rows[i].crc) << CTRL_STRIP_CRC);
      pkt(rows[i].len, rows[i].vlan);
      repeat (2) @(posedge clk);
      cause(rows[i].exp ? 32'h3 : 32'h0);
    end
    apb(1'h1, PKT_DELAY_OFF, 32'h8000_0003);
    wfl(5);
    chk(n < 5, 1'h1);
    repeat (8) @(posedge clk);
    cause(32'h1);
    apb(1'h1, MASK_OFF, 32'h1);
    pkt(16'h0100, 1'h0);
    repeat (30) @(posedge clk);
    pkt(16'h0100, 1'h0);
    wfl(80);
    chk(n >= 38 && n <= 64, 1'h1);
    repeat (8) @(posedge clk);
    chk(irq, 1'h1);
    cause(32'h1);
    @(posedge clk);
    chk(irq, 1'h0);
    apb(1'h1, PKT_DELAY_OFF, 32'h3);
    apb(1'h1, ABS_DELAY_OFF, 32'h2);
    n = 10;
    t = 0;
    for (k = 0; k < 8 && n == 10; k++) begin
      pkt(16'h0100, 1'h0);
      wfl(10);
      t += n + 2;
    end
    chk(n < 10 && t <= 48, 1'h1);
    repeat (20) @(posedge clk);
    wfl(300);
    chk(n, 300);
    cause(32'h1);
    apb(1'h1, PKT_DELAY_OFF, 32'h2);
    apb(1'h1, ABS_DELAY_OFF, 32'h0);
    apb(1'h1, SMALL_THR_OFF, 32'h40);
    for (k = 0; k < 2; k++) begin
      apb(1'h1, RX_CTRL_OFF, 32'(k) << CTRL_KEEP_TIMERS);
      pkt(16'h0020, 1'h0);
      wfl(60);
      chk(n < 60, k);
      repeat (20) @(posedge clk);
      cause(32'h3);
    end
    apb(1'h1, PKT_DELAY_OFF, 32'h0);
    apb(1'h1, RX_CTRL_OFF, 32'h0);
    pkt(16'h0100, 1'h0);
    wfl(3);
    chk(n < 3, 1'h1);
    repeat (8) @(posedge clk);
    cause(32'h1);
    full <= 1'h1;
    fwr <= 1'h1;
    @(posedge clk);
    full <= 1'h0;
    repeat (2) @(posedge clk);
    chk(drop, 1'h1);
    eop <= 1'h1;
    @(posedge clk);
    eop <= 1'h0;
    repeat (2) @(posedge clk);
    fwr <= 1'h0;
    chk(drop, 1'h0);
    cause(32'h8);
    for (k = 0; k < 4; k++) begin
      apb(1'h1, RX_CTRL_OFF, 32'(k));
      free <= 16'h0008;
      repeat (2) @(posedge clk);
      free <= 16'h0008 >> (k == 3 ? 3 : k + 1);
      repeat (3) @(posedge clk);
      cause(32'h4);
    end
    apb(1'h1, RX_CTRL_OFF, 32'h10);
    slow <= 1'h1;
    apb(1'h1, PKT_DELAY_OFF, 32'h8000_0002);
    wfl(5);
    chk(n < 5, 1'h1);
    n = 0;
    while (head !== 1'h1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(n < 40, 1'h1);
    repeat (4) @(posedge clk);
    cause(32'h1);
    pkt(16'h0100, 1'h0);
    wfl(80);
    chk(n < 80, 1'h1);
    repeat (30) @(posedge clk);
    cause(32'h1);
    rst_n <= 1'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    for (k = 0; k < 8; k++) begin
      apb(1'h0, 8'(4 * k), 32'h0);
      chk(rd, rst_v[k]);
    end
    apb(1'h0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk(perr, 1'h1);
    final_report();
  end
endmodule
`default_nettype wire
